/* acquisition_control_registers.v */
// Register bank and conversion sequencer of the acquisition front end.
// Overview of operation
// (R1) Oscillator enable bit resets to one; clearing it stops the oscillator.
// (R2) Pad D1 drives its stored value only when output and no external ref.
// (R3) Pad D0 drives its stored value only when output and no ref output.
// (R4) Writing 0x96 to the address command takes address low bits from pads.
// (R5) Result reads as low byte at 0x50 and high byte at 0x51.
// (R6) Writing one to the start bit begins a conversion.
// (R7) Elementary conversions per result equal two to the field value.
// (R8) Input is chopped between successive elementary conversions.
// (R9) Oversampling per elementary conversion is two to three plus field.
// (R10) Continuous bit makes the sequencer restart after each result.
// (R11) Converter bias field selects converter bias current, reset 11.
// (R12) Amplifier bias field selects amplifier bias current, reset 11.
// (R13) Sample rate field selects converter sampling frequency, reset 00.
// (R14) Default bit loads default converter setup and starts a conversion.
// (R15) Five-bit input multiplexer field selects the input channel setup.
// (R16) Reference chop forced 0, forced 1, per elementary conversion, or half rate.
// (R17) Pump force-on turns the charge pump on and beats force-off.
// (R18) Pump force-off, reset one, keeps the pump off unless forced on.
// (R19) Reference output bit routes the reference onto pad D0.
// (R20) External reference bit takes the reference from pad D1.
// (R21) Bias codes 00, 01, 11 give quarter, half, full current.
// (R22) Every register takes its listed reset value after reset.
// (R23) Busy flag reads one while a conversion runs, zero when idle.
// (R24) Pad readback bits show synchronised pad levels; writes are ignored.
// (R25) Four enable bits power converter and three stages, reset off.
`timescale 1ns/1ps
`include "acq_regs_consts.vh"
module acquisition_control_registers (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // Register access from the bus transaction engine
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_r,
  output reg         reg_rvalid_r,
  // General purpose pads
  input  wire        pad0_in,
  input  wire        pad1_in,
  output wire        pad0_out,
  output wire        pad0_oe,
  output wire        pad1_out,
  output wire        pad1_oe,
  // Address and timeout controls to the bus engine
  output wire        address_from_pads,
  output wire [1:0]  address_low_bits,
  output wire        timeout_enable,
  // Oscillator and reference controls
  output wire        oscillator_on,
  output wire        pump_on,
  output wire        reference_out_on_pad0,
  output wire        reference_in_on_pad1,
  output wire        reference_select,
  // Analog chain settings
  output wire [1:0]  converter_bias_select,
  output wire [1:0]  amplifier_bias_select,
  output wire [3:0]  stage_enable,
  output wire [1:0]  sample_rate_select,
  output wire [1:0]  stage2_gain,
  output wire [3:0]  stage2_offset,
  output wire        stage1_gain,
  output wire [6:0]  stage3_gain,
  output wire [6:0]  stage3_offset_value,
  output wire [4:0]  input_select,
  output wire [2:0]  oversampling_exp,
  output wire [1:0]  elementary_count_exp,
  // Conversion sequencing with the analog chain
  input  wire        sample_strobe,
  input  wire [15:0] conv_data,
  output wire        conv_busy,
  output reg         input_chop_r,
  output reg         reference_chop_r,
  output reg         elem_done_r
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg [7:0]  osc_ctrl_r;
  reg [7:0]  pad_out_r;
  reg [7:0]  timeout_r;
  reg [7:0]  addr_cmd_r;
  reg [15:0] result_r;
  reg [7:0]  seq_cfg_r;
  reg [7:0]  bias_en_r;
  reg [7:0]  rate_stage2_r;
  reg [7:0]  gain13_r;
  reg [7:0]  stage3_ofs_r;
  reg [7:0]  insel_r;
  reg [7:0]  mode_r;
  reg        seq_state_r;
  reg [10:0] sample_cnt_r;
  reg [3:0]  elem_cnt_r;
  reg        half_phase_r;

  wire pad0_level;
  wire pad1_level;
  wire wr_seq;
  wire wr_insel;
  wire start_take;
  wire elem_end;
  wire result_end;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [10:0] pow2_11;
    input [3:0] e;
    begin
      pow2_11 = `CNT_ONE << e;
    end
  endfunction

  function is_wr;
    input [7:0] ofs;
    begin
      is_wr = reg_wr && (reg_addr == ofs);
    end
  endfunction

  // ****************************************************************
  // Pad input synchronisers
  // ****************************************************************
  pad_sync u_sync0 (.clk_sys(clk_sys), .rst(rst), .pad_in(pad0_in),
                    .level_r(pad0_level));

  pad_sync u_sync1 (.clk_sys(clk_sys), .rst(rst), .pad_in(pad1_in),
                    .level_r(pad1_level));

  // ****************************************************************
  // Register writes
  // ****************************************************************
  assign wr_seq   = is_wr(`OFS_SEQ_CFG);
  assign wr_insel = is_wr(`OFS_INSEL);

  // (R22) reset values
  always @(posedge clk_sys) begin
    if (rst) begin
      osc_ctrl_r    <= `RST_OSC_CTRL;
      pad_out_r     <= `RST_PAD_OUT;
      timeout_r     <= `RST_TIMEOUT;
      addr_cmd_r    <= `RST_ADDR_CMD;
      bias_en_r     <= `RST_BIAS_EN;
      rate_stage2_r <= `RST_RATE_STAGE2;
      gain13_r      <= `RST_GAIN13;
      stage3_ofs_r  <= `RST_STAGE3_OFS;
      mode_r        <= `RST_MODE;
    end else begin
      if (is_wr(`OFS_OSC_CTRL))
        osc_ctrl_r <= reg_wdata & `MASK_OSC_CTRL;
      if (is_wr(`OFS_PAD_OUT))
        pad_out_r <= (reg_wdata & `MASK_PAD_OUT) | `FIX_PAD_OUT;
      if (is_wr(`OFS_TIMEOUT))
        timeout_r <= reg_wdata;
      if (is_wr(`OFS_ADDR_CMD))
        addr_cmd_r <= reg_wdata;
      if (is_wr(`OFS_STAGE3_OFS))
        stage3_ofs_r <= reg_wdata;
      if (is_wr(`OFS_MODE))
        mode_r <= (reg_wdata & `MASK_MODE) | `FIX_MODE;
      // (R14) default setup load
      if (wr_insel && reg_wdata[`BIT_DEFAULT]) begin
        bias_en_r     <= `RST_BIAS_EN;
        rate_stage2_r <= `RST_RATE_STAGE2;
        gain13_r      <= `RST_GAIN13;
      end else begin
        if (is_wr(`OFS_BIAS_EN))
          bias_en_r <= reg_wdata;
        if (is_wr(`OFS_RATE_STAGE2))
          rate_stage2_r <= reg_wdata;
        if (is_wr(`OFS_GAIN13))
          gain13_r <= reg_wdata;
      end
    end
  end

  // Start is taken by the idle sequencer; a write in the same cycle wins.
  always @(posedge clk_sys) begin
    if (rst) begin
      seq_cfg_r <= `RST_SEQ_CFG;
    end else begin
      if (start_take)
        seq_cfg_r[`BIT_START] <= 1'b0;
      if (wr_insel && reg_wdata[`BIT_DEFAULT]) begin
        seq_cfg_r <= `RST_SEQ_CFG;
        // (R14) default also starts
        seq_cfg_r[`BIT_START] <= 1'b1;
      end else if (wr_seq) begin
        // (R6) start bit written
        seq_cfg_r <= reg_wdata & `MASK_SEQ_CFG;
      end
    end
  end

  // The default bit is a command and never reads back as set.
  always @(posedge clk_sys) begin
    if (rst) begin
      insel_r <= `RST_INSEL;
    end else if (wr_insel) begin
      insel_r <= reg_wdata & `MASK_INSEL;
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  assign start_take = (seq_state_r == `SEQ_IDLE) && seq_cfg_r[`BIT_START];
  // (R9) oversampling length
  assign elem_end   = (seq_state_r == `SEQ_RUN) && sample_strobe &&
                      (sample_cnt_r == pow2_11({1'b0, oversampling_exp} +
                                               `OSR_BASE_EXP));
  // (R7) elementary count
  assign result_end = elem_end &&
                      ({7'h00, elem_cnt_r} ==
                       pow2_11({2'b00, elementary_count_exp}));

  always @(posedge clk_sys) begin
    if (rst) begin
      seq_state_r  <= `SEQ_IDLE;
      sample_cnt_r <= `CNT_ONE;
      elem_cnt_r   <= `ELEM_ONE;
      half_phase_r <= 1'b0;
      input_chop_r <= 1'b0;
      elem_done_r  <= 1'b0;
      result_r     <= `RST_RESULT;
    end else begin
      elem_done_r <= elem_end;
      case (seq_state_r)
        `SEQ_IDLE: begin
          if (start_take) begin
            seq_state_r  <= `SEQ_RUN;
            sample_cnt_r <= `CNT_ONE;
            elem_cnt_r   <= `ELEM_ONE;
            input_chop_r <= 1'b0;
            half_phase_r <= 1'b0;
          end
        end
        `SEQ_RUN: begin
          if (result_end) begin
            // (R5) result capture
            result_r     <= conv_data;
            sample_cnt_r <= `CNT_ONE;
            elem_cnt_r   <= `ELEM_ONE;
            input_chop_r <= 1'b0;
            half_phase_r <= 1'b0;
            // (R10) continuous restart
            if (!seq_cfg_r[`BIT_CONTINUOUS]) begin
              seq_state_r <= `SEQ_IDLE;
            end
          end else if (elem_end) begin
            sample_cnt_r <= `CNT_ONE;
            elem_cnt_r   <= elem_cnt_r + `ELEM_ONE;
            // (R8) input chop toggle
            input_chop_r <= ~input_chop_r;
            half_phase_r <= ~half_phase_r;
          end else if (sample_strobe) begin
            sample_cnt_r <= sample_cnt_r + `CNT_ONE;
          end
        end
        default: seq_state_r <= `SEQ_IDLE;
      endcase
    end
  end

  // (R16) reference chop modes
  always @(posedge clk_sys) begin
    if (rst) begin
      reference_chop_r <= 1'b0;
    end else begin
      case (mode_r[`FLD_CHOP_HI:`FLD_CHOP_LO])
        `CHOP_FORCE0: reference_chop_r <= 1'b0;
        `CHOP_FORCE1: reference_chop_r <= 1'b1;
        `CHOP_EVERY: if (elem_end)
          reference_chop_r <= ~reference_chop_r;
        `CHOP_HALF: if (elem_end && half_phase_r)
          reference_chop_r <= ~reference_chop_r;
        default: reference_chop_r <= 1'b0;
      endcase
    end
  end

  // (R23) busy flag
  assign conv_busy = (seq_state_r == `SEQ_RUN);

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_r  <= `BYTE_ZERO;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `OFS_OSC_CTRL:    reg_rdata_r <= osc_ctrl_r;
          `OFS_PAD_OUT:     reg_rdata_r <= pad_out_r;
          // (R24) pad readback
          `OFS_PAD_IN:      reg_rdata_r <= {6'h00, pad1_level, pad0_level};
          `OFS_TIMEOUT:     reg_rdata_r <= timeout_r & `MASK_TIMEOUT_RD;
          `OFS_ADDR_CMD:    reg_rdata_r <= addr_cmd_r;
          // (R5) result bytes
          `OFS_RESULT_LO:   reg_rdata_r <= result_r[7:0];
          `OFS_RESULT_HI:   reg_rdata_r <= result_r[15:8];
          `OFS_SEQ_CFG:     reg_rdata_r <= seq_cfg_r;
          `OFS_BIAS_EN:     reg_rdata_r <= bias_en_r;
          `OFS_RATE_STAGE2: reg_rdata_r <= rate_stage2_r;
          `OFS_GAIN13:      reg_rdata_r <= gain13_r;
          `OFS_STAGE3_OFS:  reg_rdata_r <= stage3_ofs_r;
          `OFS_INSEL:       reg_rdata_r <= {conv_busy, insel_r[6:0]};
          `OFS_MODE:        reg_rdata_r <= mode_r;
          default:          reg_rdata_r <= `BYTE_ZERO;
        endcase
      end
    end
  end

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  // (R1) oscillator enable
  assign oscillator_on = osc_ctrl_r[`BIT_OSC_ON];
  // (R3) pad D0 drive
  assign pad0_oe  = pad_out_r[`BIT_PAD0_DIR] & ~mode_r[`BIT_REF_OUT_D0];
  assign pad0_out = pad_out_r[`BIT_PAD0_VAL] & pad0_oe;
  // (R2) pad D1 drive
  assign pad1_oe  = pad_out_r[`BIT_PAD1_DIR] & ~mode_r[`BIT_REF_IN_D1];
  assign pad1_out = pad_out_r[`BIT_PAD1_VAL] & pad1_oe;
  // (R4) address from pads
  assign address_from_pads = (addr_cmd_r == `ADDR_PIN_CODE);
  assign address_low_bits  = address_from_pads ? {pad1_level, pad0_level}
                                               : 2'b00;
  assign timeout_enable = timeout_r[`BIT_TIMEOUT_EN];
  // (R17) force-on priority
  // (R18) force-off otherwise
  assign pump_on = mode_r[`BIT_PUMP_ON] | ~mode_r[`BIT_PUMP_OFF];
  // (R19) reference out on D0
  assign reference_out_on_pad0 = mode_r[`BIT_REF_OUT_D0];
  // (R20) external reference on D1
  assign reference_in_on_pad1  = mode_r[`BIT_REF_IN_D1];
  assign reference_select      = insel_r[`BIT_VMUX];
  // (R11) converter bias
  // (R21) bias codes passed through
  assign converter_bias_select = bias_en_r[`FLD_CBIAS_HI:`FLD_CBIAS_LO];
  // (R12) amplifier bias
  assign amplifier_bias_select = bias_en_r[`FLD_ABIAS_HI:`FLD_ABIAS_LO];
  // (R25) stage power enables
  assign stage_enable = bias_en_r[`FLD_EN_HI:`FLD_EN_LO];
  // (R13) sample rate
  assign sample_rate_select = rate_stage2_r[`FLD_FS_HI:`FLD_FS_LO];
  assign stage2_gain   = rate_stage2_r[`FLD_G2_HI:`FLD_G2_LO];
  assign stage2_offset = rate_stage2_r[`FLD_O2_HI:`FLD_O2_LO];
  assign stage1_gain   = gain13_r[`BIT_G1];
  assign stage3_gain   = gain13_r[`FLD_G3_HI:`FLD_G3_LO];
  assign stage3_offset_value = stage3_ofs_r[`FLD_O3_HI:`FLD_O3_LO];
  // (R15) input multiplexer
  assign input_select = insel_r[`FLD_AMUX_HI:`FLD_AMUX_LO];
  assign oversampling_exp     = seq_cfg_r[`FLD_OSR_HI:`FLD_OSR_LO];
  assign elementary_count_exp = seq_cfg_r[`FLD_NELC_HI:`FLD_NELC_LO];

endmodule

/* acq_regs_consts.vh */
// Register offsets, field positions and reset values of the register bank.
`ifndef ACQ_REGS_CONSTS_VH
`define ACQ_REGS_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_OSC_CTRL      8'h30
`define OFS_PAD_OUT       8'h40
`define OFS_PAD_IN        8'h41
`define OFS_TIMEOUT       8'h42
`define OFS_ADDR_CMD      8'h43
`define OFS_RESULT_LO     8'h50
`define OFS_RESULT_HI     8'h51
`define OFS_SEQ_CFG       8'h52
`define OFS_BIAS_EN       8'h53
`define OFS_RATE_STAGE2   8'h54
`define OFS_GAIN13        8'h55
`define OFS_STAGE3_OFS    8'h56
`define OFS_INSEL         8'h57
`define OFS_MODE          8'h70

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_OSC_CTRL      8'h01
`define RST_PAD_OUT       8'hF0
`define RST_TIMEOUT       8'h00
`define RST_ADDR_CMD      8'h00
`define RST_RESULT        16'h0000
`define RST_SEQ_CFG       8'h28
`define RST_BIAS_EN       8'hF0
`define RST_RATE_STAGE2   8'h00
`define RST_GAIN13        8'h0C
`define RST_STAGE3_OFS    8'h00
`define RST_INSEL         8'h00
`define RST_MODE          8'h84

// ****************************************************************
// Read masks and fixed read values
// ****************************************************************
`define MASK_OSC_CTRL     8'h01
`define MASK_PAD_OUT      8'h3F
`define FIX_PAD_OUT       8'hC0
`define MASK_TIMEOUT_RD   8'hDF
`define MASK_SEQ_CFG      8'hFE
`define MASK_INSEL        8'h3F
`define MASK_MODE         8'h3F
`define FIX_MODE          8'h80
`define BYTE_ZERO         8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_OSC_ON        0
`define BIT_PAD1_DIR      5
`define BIT_PAD0_DIR      4
`define BIT_PAD1_VAL      1
`define BIT_PAD0_VAL      0
`define BIT_TIMEOUT_EN    5
`define BIT_START         7
`define FLD_NELC_HI       6
`define FLD_NELC_LO       5
`define FLD_OSR_HI        4
`define FLD_OSR_LO        2
`define BIT_CONTINUOUS    1
`define FLD_CBIAS_HI      7
`define FLD_CBIAS_LO      6
`define FLD_ABIAS_HI      5
`define FLD_ABIAS_LO      4
`define FLD_EN_HI         3
`define FLD_EN_LO         0
`define FLD_FS_HI         7
`define FLD_FS_LO         6
`define FLD_G2_HI         5
`define FLD_G2_LO         4
`define FLD_O2_HI         3
`define FLD_O2_LO         0
`define BIT_G1            7
`define FLD_G3_HI         6
`define FLD_G3_LO         0
`define FLD_O3_HI         6
`define FLD_O3_LO         0
`define BIT_BUSY          7
`define BIT_DEFAULT       6
`define FLD_AMUX_HI       5
`define FLD_AMUX_LO       1
`define BIT_VMUX          0
`define FLD_CHOP_HI       5
`define FLD_CHOP_LO       4
`define BIT_PUMP_ON       3
`define BIT_PUMP_OFF      2
`define BIT_REF_OUT_D0    1
`define BIT_REF_IN_D1     0

// ****************************************************************
// Commands, encodings and sequencer constants
// ****************************************************************
`define ADDR_PIN_CODE     8'h96
`define CHOP_FORCE0       2'b00
`define CHOP_FORCE1       2'b01
`define CHOP_EVERY        2'b10
`define CHOP_HALF         2'b11
`define OSR_BASE_EXP      4'h3
`define CNT_ONE           11'h001
`define ELEM_ONE          4'h1
`define SEQ_IDLE          1'b0
`define SEQ_RUN           1'b1

`endif

/* pad_sync.v */
// Three-stage input synchroniser with agreement filter for a pad level.
`timescale 1ns/1ps
module pad_sync (
  // Clock and reset
  input  wire clk_sys,
  input  wire rst,
  // Pad level in and filtered level out
  input  wire pad_in,
  output reg  level_r
);

  reg stage1_r;
  reg stage2_r;
  reg stage3_r;

  // The filtered level only moves once the last two stages agree.
  always @(posedge clk_sys) begin
    if (rst) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
      level_r  <= 1'b0;
    end else begin
      stage1_r <= pad_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      if (stage2_r == stage3_r) begin
        level_r <= stage3_r;
      end
    end
  end

endmodule

/* acq_regs_sva.sv */
// Assertion checker for the acquisition register bank ports.
`timescale 1ns/1ps
module acq_regs_sva (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Register bus
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic       reg_rvalid_r,
  // Pads, address and modes
  input wire logic       pad0_oe,
  input wire logic       pad1_oe,
  input wire logic       address_from_pads,
  input wire logic [1:0] address_low_bits,
  input wire logic       oscillator_on,
  input wire logic       pump_on,
  input wire logic       reference_out_on_pad0,
  input wire logic       reference_in_on_pad1,
  // Sequencer
  input wire logic [2:0] oversampling_exp,
  input wire logic [1:0] elementary_count_exp,
  input wire logic       sample_strobe,
  input wire logic       conv_busy,
  input wire logic       elem_done_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [15:0] strobe_cnt_r;
  logic [15:0] per_result;
  assign per_result = 16'h0001 << (oversampling_exp + elementary_count_exp + 3);
  // Counts modulator samples since the sequencer left idle.
  always @(posedge clk_sys) begin
    if (rst || !conv_busy)
      strobe_cnt_r <= 16'h0000;
    else if (sample_strobe)
      strobe_cnt_r <= strobe_cnt_r + 16'h0001;
  end
  sequence start_wr;
    reg_wr && reg_addr == 8'h52 && reg_wdata[7] && !conv_busy;
  endsequence
  sequence default_wr;
    reg_wr && reg_addr == 8'h57 && reg_wdata[6] && !conv_busy;
  endsequence
  read_answer_a: assert property (reg_rvalid_r == $past(reg_rd))
    else $error("read answer wrong");
  pad1_drive_a: assert property (pad1_oe |-> !reference_in_on_pad1)
    else $error("pad1 driven");
  pad0_drive_a: assert property (pad0_oe |-> !reference_out_on_pad0)
    else $error("pad0 driven");
  pump_on_a: assert property (reg_wr && reg_addr == 8'h70 && reg_wdata[3]
    |=> pump_on) else $error("pump not forced on");
  pump_off_a: assert property (reg_wr && reg_addr == 8'h70
    && reg_wdata[3:2] == 2'b01 |=> !pump_on) else $error("pump not off");
  osc_enable_a: assert property (reg_wr && reg_addr == 8'h30
    |=> oscillator_on == $past(reg_wdata[0])) else $error("osc enable");
  addr_cmd_a: assert property (reg_wr && reg_addr == 8'h43
    |=> address_from_pads == ($past(reg_wdata) == 8'h96))
    else $error("address command decode");
  addr_bits_a: assert property (!address_from_pads
    |-> address_low_bits == 2'b00) else $error("address bits");
  start_conv_a: assert property (start_wr |-> ##2 conv_busy)
    else $error("start ignored");
  default_conv_a: assert property (default_wr |-> ##[1:2] conv_busy)
    else $error("default ignored");
  result_len_a: assert property ($fell(conv_busy) |-> strobe_cnt_r != 0
    && (strobe_cnt_r & (per_result - 16'h0001)) == 16'h0000)
    else $error("samples per result");
  elem_pulse_a: assert property (elem_done_r |=> !elem_done_r)
    else $error("elem pulse long");
endmodule

bind acquisition_control_registers acq_regs_sva u_sva (.*);

/* adc_chain_model.sv */
// Behavioural model of the analog modulator and filter chain.
`timescale 1ns/1ps
module adc_chain_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Run request and result value
  input  wire logic        run,
  input  wire logic [15:0] value,
  // Modulator outputs
  output logic             sample_strobe,
  output logic [15:0]      conv_data
);
  // One modulator sample every second cycle while the sequencer runs.
  always @(posedge clk_sys) begin
    if (rst)
      sample_strobe <= 1'b0;
    else
      sample_strobe <= run & ~sample_strobe;
  end
  // Outside a conversion the result bus shows a pattern, not the value.
  assign conv_data = run ? value : ~value;
endmodule

/* acquisition_control_registers_tb.sv */
// Self-checking testbench for the acquisition register bank.
`timescale 1ns/1ps
module acquisition_control_registers_tb;
  logic        clk_sys, rst, reg_wr, reg_rd, ext0, ext1;
  logic [7:0]  reg_addr, reg_wdata;
  logic [15:0] value, strobes, elems;
  logic [1:0]  ichop;
  int          miscompares, checked;
  wire [7:0]   reg_rdata_r;
  wire         reg_rvalid_r, pad0_out, pad0_oe, pad1_out, pad1_oe;
  wire         pad0_in, pad1_in, address_from_pads, timeout_enable;
  wire         oscillator_on, pump_on, reference_out_on_pad0;
  wire         reference_in_on_pad1, reference_select, stage1_gain;
  wire         sample_strobe, conv_busy, input_chop_r, reference_chop_r;
  wire         elem_done_r;
  wire [1:0]   address_low_bits, converter_bias_select;
  wire [1:0]   amplifier_bias_select, sample_rate_select, stage2_gain;
  wire [1:0]   elementary_count_exp;
  wire [3:0]   stage_enable, stage2_offset;
  wire [6:0]   stage3_gain, stage3_offset_value;
  wire [4:0]   input_select;
  wire [2:0]   oversampling_exp;
  wire [15:0]  conv_data;

  acquisition_control_registers DUT (.*);
  adc_chain_model chain (.clk_sys(clk_sys), .rst(rst), .run(conv_busy),
    .value(value), .sample_strobe(sample_strobe), .conv_data(conv_data));
  // Pad wires resolve the block's drive against the outside level.
  assign pad0_in = pad0_oe ? pad0_out : ext0;
  assign pad1_in = pad1_oe ? pad1_out : ext1;

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (conv_busy && sample_strobe)
      strobes = strobes + 16'h0001;
    if (elem_done_r) begin
      elems = elems + 16'h0001;
      ichop = {ichop[0], input_chop_r};
    end
  end

  task automatic check(input string name, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp, input string name);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    check(name, reg_rvalid_r, 1'b1);
    check(name, reg_rdata_r, exp);
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (conv_busy !== lvl && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    check("busy", conv_busy, lvl);
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic t_reset();
    logic [15:0] tbl [15] = '{16'h3001, 16'h40F0, 16'h4100, 16'h4200,
      16'h4300, 16'h5000, 16'h5100, 16'h5228, 16'h53F0, 16'h5400,
      16'h550C, 16'h5600, 16'h5700, 16'h7084, 16'h3100};
    foreach (tbl[i]) rd(tbl[i][15:8], tbl[i][7:0], "reset value");
    check("osc", oscillator_on, 1'b1);
    check("pump", pump_on, 1'b0);
    check("bias", {converter_bias_select, amplifier_bias_select}, 4'hF);
    check("enables", stage_enable, 4'h0);
  endtask
  task automatic t_rw();
    logic [23:0] tbl [11] = '{24'h535A5A, 24'h54A5A5, 24'h55FFFF,
      24'h567F7F, 24'h42FFDF, 24'h573F3F, 24'h50FF00, 24'h51FF00,
      24'h41FF00, 24'h30FE00, 24'h60FF00};
    foreach (tbl[i]) begin
      wr(tbl[i][23:16], tbl[i][15:8]);
      rd(tbl[i][23:16], tbl[i][7:0], "readback");
    end
    check("cfg1", {converter_bias_select, amplifier_bias_select}, 4'h5);
    check("enable", stage_enable, 4'hA);
    check("cfg2", {sample_rate_select, stage2_gain, stage2_offset}, 8'hA5);
    check("cfg3", {stage1_gain, stage3_gain}, 8'hFF);
    check("cfg4", stage3_offset_value, 7'h7F);
    check("cfg5", {input_select, reference_select}, 6'h3F);
    check("misc", {timeout_enable, oscillator_on}, 2'b10);
    wr(8'h30, 8'h01);
    check("osc on", oscillator_on, 1'b1);
  endtask
  task automatic t_pads();
    wr(8'h40, 8'h33);
    check("drive", {pad1_oe, pad1_out, pad0_oe, pad0_out}, 4'hF);
    wr(8'h70, 8'h85);
    check("ref in", {pad1_oe, pad0_oe}, 2'b01);
    wr(8'h70, 8'h86);
    check("ref out", {pad1_oe, pad0_oe}, 2'b10);
    wr(8'h70, 8'h84);
    wr(8'h40, 8'h03);
    ext0 = 1'b1;
    repeat (4) @(negedge clk_sys);
    rd(8'h41, 8'h01, "pad levels");
    wr(8'h43, 8'h96);
    check("addr", {address_from_pads, address_low_bits}, 3'b101);
    wr(8'h43, 8'h95);
    check("addr off", {address_from_pads, address_low_bits}, 3'b000);
  endtask
  task automatic t_pump();
    logic [7:0] w;
    for (int i = 0; i < 4; i++) begin
      w = 8'(8'h80 | i << 2 | (i & 1) << 4);
      wr(8'h70, w);
      check("pump", pump_on, i[1] | !i[0]);
      rd(8'h70, w, "mode");
      check("chop", reference_chop_r, i[0]);
    end
    wr(8'h70, 8'h84);
  endtask
  task automatic t_conv(input logic [7:0] cfg, mode, input logic [15:0] ns,
    ne, v, input logic [2:0] ch);
    value = v;
    strobes = 16'h0000;
    elems = 16'h0000;
    ichop = 2'b00;
    wr(8'h70, mode);
    wr(8'h52, cfg);
    wait_busy(1'b1);
    rd(8'h57, 8'hBF, "busy flag");
    wait_busy(1'b0);
    rd(8'h50, v[7:0], "result low");
    rd(8'h51, v[15:8], "result high");
    rd(8'h52, cfg & 8'h7F, "start clear");
    check("samples", strobes, ns);
    check("elementary", elems, ne);
    check("input chop", ichop, ch[2:1]);
    check("ref chop", reference_chop_r, ch[0]);
  endtask
  task automatic t_cont();
    elems = 16'h0000;
    wr(8'h52, 8'h82);
    repeat (60) @(negedge clk_sys);
    check("continuous", {conv_busy, elems >= 16'h0003}, 2'b11);
    wr(8'h52, 8'h00);
    wait_busy(1'b0);
  endtask
  task automatic t_default();
    wr(8'h53, 8'h0F);
    wr(8'h57, 8'h40);
    wait_busy(1'b1);
    rd(8'h53, 8'hF0, "default cfg");
    rd(8'h57, 8'h80, "default bit");
    wait_busy(1'b0);
    rd(8'h52, 8'h28, "default seq");
  endtask

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ext0 = 1'b0;
    ext1 = 1'b0;
    value = 16'h0000;
    strobes = 16'h0000;
    elems = 16'h0000;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_rw();
    t_pads();
    t_pump();
    t_conv(8'h80, 8'hA4, 16'd8, 16'd1, 16'hBEEF, 3'b001);
    t_conv(8'hA0, 8'hB4, 16'd16, 16'd2, 16'h1234, 3'b100);
    t_conv(8'h84, 8'h94, 16'd16, 16'd1, 16'h8001, 3'b001);
    t_cont();
    t_default();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    print_verdict();
  end
endmodule
